// ===== hw/sia_consts.svh
// Constants of the subtract-instruction execution block: offsets, fields, store size, boundaries, resets.
// Assumes it is included by bare name from the top design module sia_alu.
`ifndef SIA_CONSTS_SVH
`define SIA_CONSTS_SVH

// Register byte offsets on the APB slave
`define SIA_OFS_INSTR 12'h000
`define SIA_OFS_ACC 12'h004
`define SIA_OFS_STATUS 12'h008
`define SIA_OFS_CFG 12'h00C
`define SIA_OFS_IDXBASE 12'h010
`define SIA_OFS_FILE_LO 12'h080
`define SIA_OFS_FILE_HI 12'h0FC

// File register store: entries and index width
`define SIA_FILE_DEPTH 32
`define SIA_FILE_IW 5

// Instruction opcode fields
`define SIA_OPC_FILE_MSB 15
`define SIA_OPC_FILE_LSB 10
`define SIA_OPC_FILE_VAL 6'h17
`define SIA_OPC_LIT_VAL 8'h08
`define SIA_BIT_DEST 9
`define SIA_BIT_ASEL 8

// Status field positions
`define SIA_ST_C 0
`define SIA_ST_DC 1
`define SIA_ST_Z 2
`define SIA_ST_OV 3
`define SIA_ST_N 4

// Config field positions
`define SIA_CFG_BANK_LSB 0
`define SIA_CFG_BANK_MSB 3
`define SIA_CFG_EXT 8

// Addressing boundaries
`define SIA_IDX_MAX 8'h5F
`define SIA_ACC_SPLIT 8'h80
`define SIA_ACC_HI_BANK 4'hF

// Reset values
`define SIA_RST_ACC 8'h00
`define SIA_RST_STATUS 5'h00
`define SIA_RST_BANK 4'h0
`define SIA_RST_IDXBASE 12'h000
`define SIA_RST_INSTR 16'h0000
`define SIA_RST_EXT 1'b0
`define SIA_RST_FILE 8'h00

`endif

// ===== hw/sia_pkg.sv
// Types shared by the subtract-instruction execution block.
// Assumes sia_consts.svh sits beside it.
package sia_pkg;
  // Execution sequencer, one-hot
  typedef enum logic [1:0] {
    SIA_IDLE = 2'b01,
    SIA_EXEC = 2'b10
  } sia_state_t;
endpackage

// ===== hw/sia_sub.sv
// Eight-bit subtractor with status flags: minuend minus subtrahend.
// Assumes purely combinational use from the main module on the same clock.
`timescale 1ns/10ps
module sia_sub (
  input wire logic [7:0] minuend_in,
  input wire logic [7:0] subtrahend_in,
  output logic [7:0] diff_out,
  output logic borrow_inv_out,
  output logic half_carry_out,
  output logic zero_out,
  output logic wrap_out,
  output logic sign_out
);
  // Nine-bit difference keeps the borrow out
  wire [8:0] full_diff = {1'b0, minuend_in} - {1'b0, subtrahend_in};
  // Five-bit low nibble difference for half carry
  wire [4:0] nib_diff = {1'b0, minuend_in[3:0]} - {1'b0, subtrahend_in[3:0]};

  assign diff_out = full_diff[7:0];
  assign borrow_inv_out = ~full_diff[8];
  // Half carry is also inverted borrow, from bit 3
  assign half_carry_out = ~nib_diff[4];
  assign zero_out = (full_diff[7:0] == 8'h00);
  // Signed wrap: operand signs differ and result sign leaves minuend sign
  assign wrap_out = (minuend_in[7] ^ subtrahend_in[7]) & (full_diff[7] ^ minuend_in[7]);
  assign sign_out = full_diff[7];
endmodule

// ===== hw/sia_alu.sv
// Top of the subtract-instruction execution block with its APB register slave.
// Assumes an APB master on CLOCK_IN; all inputs are from that same clock domain.
//
// How it works
// - file minus accumulator, all five flags
// - target bit zero writes accumulator
// - target bit one writes source register
// - selector zero picks the access bank
// - selector one uses bank pointer register
// - extended, selector zero, low address: indexed
// - literal minus accumulator into accumulator
// - result goes where target bit says
//
// Our own choices: the APB register port and the address map.
`include "sia_consts.svh"
`timescale 1ns/10ps
module sia_alu (
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT
);
  // Sequencer state
  sia_pkg::sia_state_t state_r;
  sia_pkg::sia_state_t state_nxt;
  // Architectural state
  logic [7:0] acc_r; // Accumulator
  logic [4:0] status_r; // N, OV, Z, DC, C
  logic [3:0] bank_pointer_register_r; // Bank pointer
  logic ext_en_r; // Extended instruction set enable
  logic [11:0] idx_base_r; // Base for indexed literal offset addressing
  logic [15:0] instr_r; // Last instruction word written
  logic [7:0] file_mem_r [`SIA_FILE_DEPTH]; // File register store
  // Bus answer flops
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // Bus phase decode
  wire access_ph = PSEL_IN & PENABLE_IN;
  // Answer one cycle into the access phase, never while an instruction runs
  // Holding the answer off during execute means a bus write never meets
  // an execute write to the accumulator or a store entry at the same edge
  wire pready_nxt = access_ph & ~pready_r & (state_r == sia_pkg::SIA_IDLE);
  // Transfer completes at this edge
  wire xfer_done = access_ph & pready_r;
  wire wr_done = xfer_done & PWRITE_IN;
  // Register selects
  wire sel_instr = (PADDR_IN == `SIA_OFS_INSTR);
  wire sel_acc = (PADDR_IN == `SIA_OFS_ACC);
  wire sel_status = (PADDR_IN == `SIA_OFS_STATUS);
  wire sel_cfg = (PADDR_IN == `SIA_OFS_CFG);
  wire sel_idx = (PADDR_IN == `SIA_OFS_IDXBASE);
  wire sel_file = (PADDR_IN >= `SIA_OFS_FILE_LO) & (PADDR_IN <= `SIA_OFS_FILE_HI) & (PADDR_IN[1:0] == 2'b00);
  wire sel_any = sel_instr | sel_acc | sel_status | sel_cfg | sel_idx | sel_file;
  // Bus index into the file store, word aligned
  wire [`SIA_FILE_IW-1:0] bus_idx = PADDR_IN[`SIA_FILE_IW+1:2];

  // Instruction decode
  wire [7:0] lit_f = instr_r[7:0];
  wire is_file_op = (instr_r[`SIA_OPC_FILE_MSB:`SIA_OPC_FILE_LSB] == `SIA_OPC_FILE_VAL);
  wire is_lit_op = (instr_r[15:8] == `SIA_OPC_LIT_VAL);
  wire dest_file = instr_r[`SIA_BIT_DEST];
  wire asel_bank = instr_r[`SIA_BIT_ASEL];

  // indexed when extended and low address
  wire use_indexed = ext_en_r & ~asel_bank & (lit_f <= `SIA_IDX_MAX);
  wire [11:0] addr_indexed = idx_base_r + {4'h0, lit_f};
  // access bank splits low and high halves
  wire [11:0] addr_access = (lit_f < `SIA_ACC_SPLIT) ? {4'h0, lit_f} : {`SIA_ACC_HI_BANK, lit_f};
  // bank pointer supplies the upper bits
  wire [11:0] addr_banked = {bank_pointer_register_r, lit_f};
  wire [11:0] op_addr = asel_bank ? addr_banked : (use_indexed ? addr_indexed : addr_access);
  // Store is small, so resolved addresses alias onto its low bits
  // Limitation: software must not expect different banks to be distinct here
  wire [`SIA_FILE_IW-1:0] op_idx = op_addr[`SIA_FILE_IW-1:0];
  wire [7:0] file_val = file_mem_r[op_idx];

  wire [7:0] minuend = is_file_op ? file_val : lit_f;
  wire [7:0] diff;
  wire f_c;
  wire f_dc;
  wire f_z;
  wire f_ov;
  wire f_n;

  // Shared subtractor for both instructions
  sia_sub u_sub (
    .minuend_in(minuend),
    .subtrahend_in(acc_r),
    .diff_out(diff),
    .borrow_inv_out(f_c),
    .half_carry_out(f_dc),
    .zero_out(f_z),
    .wrap_out(f_ov),
    .sign_out(f_n)
  );

  // Execute strobe and destination steering
  // Other opcodes pass through execute but touch no register or flag
  wire exec_go = (state_r == sia_pkg::SIA_EXEC) & (is_file_op | is_lit_op);
  // write back to the source register
  wire wr_file_exec = exec_go & is_file_op & dest_file;
  // file op with target zero lands in accumulator
  // destination chosen by the target bit
  wire wr_acc_exec = exec_go & (is_lit_op | (is_file_op & ~dest_file));
  wire [31:0] status_word = {27'h000_0000, status_r};
  wire [31:0] cfg_word = {23'h00_0000, ext_en_r, 4'h0, bank_pointer_register_r};

  // Read data mux; unmapped reads return zero
  // Answer data is registered so the read port comes straight from a flop
  wire [31:0] rd_word = sel_instr ? {16'h0000, instr_r} :
                        sel_acc ? {24'h00_0000, acc_r} :
                        sel_status ? status_word :
                        sel_cfg ? cfg_word :
                        sel_idx ? {20'h0_0000, idx_base_r} :
                        sel_file ? {24'h00_0000, file_mem_r[bus_idx]} : 32'h0000_0000;

  // Sequencer: a write of the instruction word starts one execute cycle
  always_comb begin
    case (state_r)
      sia_pkg::SIA_IDLE: state_nxt = (wr_done & sel_instr) ? sia_pkg::SIA_EXEC : sia_pkg::SIA_IDLE;
      sia_pkg::SIA_EXEC: state_nxt = sia_pkg::SIA_IDLE;
      default: state_nxt = sia_pkg::SIA_IDLE;
    endcase
  end

  // State and bus answer flops
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      state_r <= sia_pkg::SIA_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      pready_r <= pready_nxt;
      // Error flags unmapped addresses alongside the ready
      pslverr_r <= pready_nxt & ~sel_any;
      prdata_r <= (pready_nxt & ~PWRITE_IN) ? rd_word : 32'h0000_0000;
    end
  end

  // Instruction and configuration registers; status is read only
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      instr_r <= `SIA_RST_INSTR;
      bank_pointer_register_r <= `SIA_RST_BANK;
      ext_en_r <= `SIA_RST_EXT;
      idx_base_r <= `SIA_RST_IDXBASE;
    end else if (wr_done) begin
      if (sel_instr) begin
        instr_r <= PWDATA_IN[15:0];
      end
      if (sel_cfg) begin
        bank_pointer_register_r <= PWDATA_IN[`SIA_CFG_BANK_MSB:`SIA_CFG_BANK_LSB];
        ext_en_r <= PWDATA_IN[`SIA_CFG_EXT];
      end
      if (sel_idx) begin
        idx_base_r <= PWDATA_IN[11:0];
      end
    end
  end

  // Accumulator: execution and bus never meet, the bus is held off during execute
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      acc_r <= `SIA_RST_ACC;
    end else if (wr_acc_exec) begin
      acc_r <= diff;
    end else if (wr_done & sel_acc) begin
      acc_r <= PWDATA_IN[7:0];
    end
  end

  // all five flags updated per operation
  // Only execution writes status, so no set and clear can ever collide
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      status_r <= `SIA_RST_STATUS;
    end else if (exec_go) begin
      status_r[`SIA_ST_C] <= f_c;
      status_r[`SIA_ST_DC] <= f_dc;
      status_r[`SIA_ST_Z] <= f_z;
      status_r[`SIA_ST_OV] <= f_ov;
      status_r[`SIA_ST_N] <= f_n;
    end
  end

  // File store, one flop group per entry
  // Execute write outranks the bus; the stall keeps them apart anyway
  genvar gi;
  generate
    for (gi = 0; gi < `SIA_FILE_DEPTH; gi = gi + 1) begin : g_file
      wire hit_exec = wr_file_exec & (op_idx == gi[`SIA_FILE_IW-1:0]);
      wire hit_bus = wr_done & sel_file & (bus_idx == gi[`SIA_FILE_IW-1:0]);
      // Entry update: execution first, then software
      always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
          file_mem_r[gi] <= `SIA_RST_FILE;
        end else if (hit_exec) begin
          file_mem_r[gi] <= diff;
        end else if (hit_bus) begin
          file_mem_r[gi] <= PWDATA_IN[7:0];
        end
      end
    end
  endgenerate

  // Outputs straight from flops
  // Error and read data stand for the one cycle that ready stands
  assign PRDATA_OUT = prdata_r;
  assign PREADY_OUT = pready_r;
  assign PSLVERR_OUT = pslverr_r;
endmodule

// ===== tb/sia_alu_monitor.sv
// APB-side checker for the subtract execution block.
// Assumes it is bound to sia_alu and sees only that module's ports.
`timescale 1ns/10ps
module sia_alu_monitor (
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);
  // Access phase and read answer
  wire acc_w = PSEL_IN && PENABLE_IN;
  wire rd_w = PREADY_OUT && !PWRITE_IN;
  // Byte-wide places: accumulator and file store
  wire byte_w = PADDR_IN == 12'h004 || (PADDR_IN >= 12'h080 && PADDR_IN <= 12'h0FC);
  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready longer than one cycle");
  ready_access_a: assert property (PREADY_OUT |-> acc_w) else $error("ready outside access phase");
  err_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("error without ready");
  wait_state_a: assert property ($rose(acc_w) |-> !PREADY_OUT ##[1:2] PREADY_OUT) else $error("bad wait count");
  idle_data_a: assert property (!rd_w |-> PRDATA_OUT == 32'h0000_0000) else $error("data outside read");
  err_data_a: assert property (rd_w && PSLVERR_OUT |-> PRDATA_OUT == 32'h0000_0000) else $error("refused read data");
  status_width_a: assert property (rd_w && PADDR_IN == 12'h008 |-> PRDATA_OUT[31:5] == 27'h0) else $error("status");
  byte_width_a: assert property (rd_w && byte_w |-> PRDATA_OUT[31:8] == 24'h00_0000) else $error("byte reg");
  // Main scenarios seen
  cover property (PREADY_OUT && PWRITE_IN);
  cover property (rd_w && PADDR_IN == 12'h008);
  cover property (PSLVERR_OUT);
endmodule
bind sia_alu sia_alu_monitor u_mon (.CLOCK_IN(CLOCK_IN), .SRST_IN(SRST_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT));

// ===== tb/test_subtract_instruction_alu.sv
// Random and corner-case bench for the subtract execution block over APB.
// Assumes sia_alu with its bound checker; one clock, synchronous reset.
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module test_subtract_instruction_alu;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  int n_fail = 0;
  int num_checks = 0;
  int k;
  // Reference model of the block state
  logic [7:0] acc, f;
  logic [7:0] st [32];
  logic [12:0] res;
  logic [11:0] idx, ad;
  logic [3:0] bank;
  logic ext;
  logic [4:0] stat, e;
  logic [15:0] ins;
  always #5 clk = ~clk;
  sia_alu dut (.CLOCK_IN(clk), .SRST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
  // Difference with flags packed as N, OV, Z, DC, C, result
  function automatic logic [12:0] sub(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = a - b;
    return {d[7], a[7] != b[7] && d[7] != a[7], d == 8'h00, a[3:0] >= b[3:0], a >= b, d};
  endfunction
  // One APB transfer; pready is sampled at the rising edge, exactly as the slave commits
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Values read just after the edge are those the slave saw at it
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Load a store entry and the accumulator
  task ld(input logic [4:0] a, input logic [7:0] v, input logic [7:0] w);
    st[a] = v;
    acc = w;
    apb(1'b1, {5'h01, a, 2'b00}, {24'h00_0000, v});
    apb(1'b1, 12'h004, {24'h00_0000, w});
  endtask
  // Bank pointer, extended enable and index base
  task cfg(input logic [3:0] b, input logic x, input logic [11:0] base);
    bank = b;
    ext = x;
    idx = base;
    apb(1'b1, 12'h00C, {23'h0, x, 4'h0, b});
    apb(1'b1, 12'h010, {20'h0_0000, base});
  endtask
  // Predict, execute, then read back accumulator, status and the touched entry
  task op(input logic [15:0] i);
    e = 5'h00;
    if (i[15:10] == 6'h17) begin
      f = i[7:0];
      ad = i[8] ? {bank, f} : (ext && f <= 8'h5F) ? idx + {4'h0, f} : {f[7] ? 4'hF : 4'h0, f};
      e = ad[4:0];
      res = sub(st[e], acc);
      if (i[9]) st[e] = res[7:0];
      else acc = res[7:0];
      stat = res[12:8];
    end else if (i[15:8] == 8'h08) begin
      res = sub(i[7:0], acc);
      acc = res[7:0];
      stat = res[12:8];
    end
    apb(1'b1, 12'h000, {16'h0000, i});
    apb(1'b0, 12'h004, '0);
    `CHK(rd, {24'h00_0000, acc})
    apb(1'b0, 12'h008, '0);
    `CHK(rd, {27'h0, stat})
    `CHK(rd[0], stat[0])
    apb(1'b0, {5'h01, e, 2'b00}, '0);
    `CHK(rd, {24'h00_0000, st[e]})
  endtask
  task summarize;
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial begin
    k = $urandom(27824);
    foreach (st[j]) st[j] = 8'h00;
    acc = 8'h00;
    stat = 5'h00;
    bank = 4'h0;
    ext = 1'b0;
    idx = 12'h000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Unmapped place is refused
    apb(1'b0, 12'h040, '0);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    ld(5'h01, 8'h03, 8'h02);
    op(16'h5F01);
    ld(5'h01, 8'h02, 8'h02);
    op(16'h5C01);
    ld(5'h01, 8'h02, 8'h03);
    op(16'h5E01);
    for (k = 1; k <= 3; k++) begin
      ld(5'h00, 8'h00, 8'(k));
      op(16'h0802);
    end
    // Indexed boundary 5F against 60, then bank pointer use
    cfg(4'h5, 1'b1, 12'h00A);
    op(16'h5C5F);
    op(16'h5C60);
    op(16'h5D07);
    for (k = 0; k < 60; k++) begin
      cfg(4'($urandom), 1'($urandom), 12'($urandom));
      ld(5'($urandom), 8'($urandom), 8'($urandom));
      ins = 16'($urandom);
      case ($urandom % 3)
        0: ins[15:10] = 6'h17;
        1: ins[15:8] = 8'h08;
        default: ;
      endcase
      op(ins);
    end
    summarize();
  end
  // Hang guard, far beyond the expected run
  initial begin
    #300000;
    n_fail++;
    summarize();
  end
endmodule
